/* logic/pca_counter_array.sv */
// Counter, timebase, snapshot read, event flags and interrupt tree, on AXI4-Lite
`timescale 1ns/100ps
`include "pca_regs.svh"

module pca_counter_array #(
    parameter int CHANNELS = 5
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic external_count_input,
    input wire logic xosc_div8_in,
    input wire logic timer0_overflow,
    input wire logic cpu_idle,
    input wire logic [CHANNELS-1:0] channel_event,
    output logic [15:0] count_value,
    output pca_pkg::mode_t mode_o,
    output logic irq_request,
    output logic cpu_irq
);
    import pca_pkg::*;

    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // True when the address names a mapped register
    function automatic logic is_mapped(input logic [11:0] a);
        return a == `ADDR_MODE || a == `ADDR_COUNT_LOW || a == `ADDR_COUNT_HIGH ||
               a == `ADDR_STATUS || a == `ADDR_ENABLE || a == `ADDR_IRQ_CTRL;
    endfunction

    // Carry out of bit 8..11 happens when the lower bits are all ones
    function automatic logic low_bits_full(input logic [15:0] c, input logic [1:0] len);
        logic [3:0] top;
        top = c[11:8];
        case (len)
            2'b00: low_bits_full = &c[7:0];
            2'b01: low_bits_full = &c[7:0] & top[0];
            2'b10: low_bits_full = &c[7:0] & (&top[1:0]);
            default: low_bits_full = &c[7:0] & (&top[2:0]);
        endcase
    endfunction

    mode_t mode_r;
    logic [15:0] count_r;
    logic [7:0] snapshot_r;
    event_t status_r;
    event_t enable_r;
    logic global_en_r;
    logic array_en_r;
    logic [3:0] presc_r;
    logic [2:0] eci_sync_r;
    logic [2:0] xosc_sync_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic rvalid_r;
    logic [1:0] rresp_r;
    logic [31:0] rdata_r;
    logic wr_take;
    logic rd_take;
    logic [31:0] wmask;
    logic [31:0] wval;
    logic tick;
    logic run;
    logic wr_low;
    logic wr_high;
    logic ovf_set;
    logic inter_set;
    event_t set_vec;
    event_t clr_vec;

    // Write channel: address and data taken together, one write in flight
    assign wr_take = s_axi_awvalid & s_axi_wvalid & ~bvalid_r;
    assign s_axi_awready = wr_take;
    assign s_axi_wready = wr_take;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;

    // Read channel: one read in flight, data from a register
    assign rd_take = s_axi_arvalid & ~rvalid_r;
    assign s_axi_arready = ~rvalid_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rresp = rresp_r;
    assign s_axi_rdata = rdata_r;

    // Byte lanes turned into a bit mask
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            wmask[i*8 +: 8] = {8{s_axi_wstrb[i]}};
        end
        wval = s_axi_wdata & wmask;
    end

    // Write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
        end else if (wr_take) begin
            bvalid_r <= 1'b1;
            bresp_r <= is_mapped(s_axi_awaddr) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_r <= 1'b0;
        end
    end

    // Read data; a low byte read also latches the high byte
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rresp_r <= RESP_OKAY;
            rdata_r <= 32'h0000_0000;
        end else if (rd_take) begin
            rvalid_r <= 1'b1;
            rresp_r <= is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            case (s_axi_araddr)
                `ADDR_MODE: rdata_r <= {25'h000_0000, mode_r};
                `ADDR_COUNT_LOW: rdata_r <= {24'h00_0000, count_r[7:0]};
                `ADDR_COUNT_HIGH: rdata_r <= {24'h00_0000, snapshot_r}; // [R2]
                `ADDR_STATUS: rdata_r <= {25'h000_0000, status_r};
                `ADDR_ENABLE: rdata_r <= {25'h000_0000, enable_r};
                `ADDR_IRQ_CTRL: rdata_r <= {30'h0000_0000, array_en_r, global_en_r};
                default: rdata_r <= 32'h0000_0000;
            endcase
        end else if (s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    // Snapshot of the high byte on a low byte read
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            snapshot_r <= 8'h00;
        end else if (rd_take && s_axi_araddr == `ADDR_COUNT_LOW) begin
            snapshot_r <= count_r[15:8]; // [R2]
        end
    end

    // Mode register; while the watchdog is on only its own bit is writable
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_r <= `MODE_RESET; // [R17]
        end else if (wr_take && s_axi_awaddr == `ADDR_MODE && s_axi_wstrb[0]) begin
            if (mode_r.wdt_enable) begin
                mode_r.wdt_enable <= s_axi_wdata[6]; // [R17]
            end else begin
                mode_r <= s_axi_wdata[6:0];
            end
        end
    end

    // Enables of the interrupt tree
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            enable_r <= '0;
            global_en_r <= 1'b0;
            array_en_r <= 1'b0;
        end else if (wr_take && s_axi_wstrb[0]) begin
            if (s_axi_awaddr == `ADDR_ENABLE) begin
                enable_r <= s_axi_wdata[6:0];
            end
            if (s_axi_awaddr == `ADDR_IRQ_CTRL) begin
                global_en_r <= s_axi_wdata[`IRQ_GLOBAL_BIT];
                array_en_r <= s_axi_wdata[`IRQ_ARRAY_BIT];
            end
        end
    end

    // Two-flop synchronisers plus one flop for edge detection
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            eci_sync_r <= 3'b111;
            xosc_sync_r <= 3'b000;
        end else begin
            eci_sync_r <= {eci_sync_r[1:0], external_count_input};
            xosc_sync_r <= {xosc_sync_r[1:0], xosc_div8_in}; // [R6]
        end
    end

    // Free-running prescaler, period twelve
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            presc_r <= 4'h0;
        end else if (presc_r == `DIV12_LAST) begin
            presc_r <= 4'h0;
        end else begin
            presc_r <= presc_r + 4'h1;
        end
    end

    // Timebase selector; reserved codes give no tick
    always_comb begin
        case (mode_r.timebase_select)
            TB_DIV12: tick = presc_r == `DIV12_LAST; // [R4]
            TB_DIV4: tick = presc_r[1:0] == `DIV4_PHASE; // [R4]
            TB_TIMER0: tick = timer0_overflow; // [R4]
            TB_EXT_FALL: tick = eci_sync_r[2] & ~eci_sync_r[1]; // [R4] [R5]
            TB_SYSCLK: tick = 1'b1; // [R4]
            TB_XOSC8: tick = ~xosc_sync_r[2] & xosc_sync_r[1]; // [R4] [R6]
            default: tick = 1'b0;
        endcase
    end

    // Counting runs unless idle suspend is set and the CPU idles
    assign run = ~(mode_r.idle_suspend & cpu_idle); // [R10] [R19]

    assign wr_low = wr_take && s_axi_awaddr == `ADDR_COUNT_LOW && s_axi_wstrb[0] &&
                    !mode_r.wdt_enable;
    assign wr_high = wr_take && s_axi_awaddr == `ADDR_COUNT_HIGH && s_axi_wstrb[0] &&
                     !mode_r.wdt_enable;

    // The 16-bit counter; software byte writes win over the increment
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_r <= 16'h0000;
        end else begin
            if (run && tick) begin
                count_r <= count_r + 16'h0001; // [R1] [R3] [R18]
            end
            if (wr_low) begin
                count_r[7:0] <= s_axi_wdata[7:0];
            end
            if (wr_high) begin
                count_r[15:8] <= s_axi_wdata[7:0];
            end
        end
    end

    assign count_value = count_r; // [R16]
    assign mode_o = mode_r;

    // Hardware events of this cycle
    assign ovf_set = run && tick && count_r == `COUNT_ALL_ONES; // [R7]
    assign inter_set = run && tick && low_bits_full(count_r, mode_r.cycle_len); // [R11]
    assign set_vec = {channel_event, inter_set, ovf_set}; // [R12]
    assign clr_vec = (wr_take && s_axi_awaddr == `ADDR_STATUS) ? wval[6:0] : '0;

    // Sticky flags: a set in the clearing cycle survives
    generate
        for (genvar g = 0; g < `STATUS_WIDTH; g++) begin : g_flag
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    status_r[g] <= 1'b0;
                end else begin
                    status_r[g] <= (status_r[g] & ~clr_vec[g]) | set_vec[g]; // [R9] [R13]
                end
            end
        end
    endgenerate

    // Interrupt tree
    assign irq_request = |(status_r & enable_r); // [R8] [R14]
    assign cpu_irq = irq_request & global_en_r & array_en_r; // [R15]

    // Checks
    chk_wrap_sets_flag: assert property (@(posedge aclk) disable iff (!aresetn) // [R7]
        ovf_set |=> status_r.overflow)
        else $error("wrap did not set overflow flag");

    chk_snapshot_value: assert property (@(posedge aclk) disable iff (!aresetn) // [R2]
        rd_take && s_axi_araddr == `ADDR_COUNT_LOW |=> snapshot_r == $past(count_r[15:8]))
        else $error("snapshot missed high byte");

    chk_read_no_stall: assert property (@(posedge aclk) disable iff (!aresetn) // [R3] [R18]
        rd_take && run && tick && !wr_low && !wr_high |=> count_r == $past(count_r) + 16'h0001)
        else $error("counter did not advance during read");

    chk_div12_spacing: assert property (@(posedge aclk) disable iff (!aresetn) // [R4]
        tick && mode_r.timebase_select == TB_DIV12 && $stable(mode_r)
        |=> !tick [*8])
        else $error("clock/12 tick too close");

    chk_idle_hold: assert property (@(posedge aclk) disable iff (!aresetn) // [R19]
        mode_r.idle_suspend && cpu_idle && !wr_low && !wr_high |=> $stable(count_r))
        else $error("counter moved while suspended");

    chk_idle_runs: assert property (@(posedge aclk) disable iff (!aresetn) // [R10]
        !mode_r.idle_suspend && cpu_idle && tick && !wr_low && !wr_high
        |=> count_r != $past(count_r))
        else $error("counter stopped in idle");

    chk_flag_sticky: assert property (@(posedge aclk) disable iff (!aresetn) // [R9]
        status_r.overflow && !clr_vec.overflow |=> status_r.overflow)
        else $error("overflow flag lost without clear");

    chk_flag_unmasked: assert property (@(posedge aclk) disable iff (!aresetn) // [R12] [R13]
        channel_event[0] && !enable_r.channel[0] |=> status_r.channel[0])
        else $error("channel flag not set while disabled");

    chk_inter_flag: assert property (@(posedge aclk) disable iff (!aresetn) // [R11]
        inter_set |=> status_r.intermediate)
        else $error("intermediate flag not set");

    chk_irq_gate: assert property (@(posedge aclk) disable iff (!aresetn) // [R8] [R14]
        status_r.overflow && !enable_r.overflow && (status_r[6:1] & enable_r[6:1]) == '0
        |-> !irq_request)
        else $error("masked flag raised request");

    chk_cpu_gate: assert property (@(posedge aclk) disable iff (!aresetn) // [R15]
        cpu_irq |-> global_en_r && array_en_r && irq_request)
        else $error("cpu request without enables");

    chk_wdt_reset: assert property (@(posedge aclk) // [R17]
        !aresetn |=> mode_r.wdt_enable)
        else $error("watchdog not on after reset");

    chk_xosc_sync: assert property (@(posedge aclk) disable iff (!aresetn) // [R6]
        mode_r.timebase_select == TB_XOSC8 && tick
        |-> $past(xosc_div8_in, 2) && !$past(xosc_div8_in, 3))
        else $error("oscillator tick not synchronised");

    // Timebase, wrap, clear, request and lockout checks
    chk_ext_fall_sync: assert property (@(posedge aclk) disable iff (!aresetn) // [R4] [R5]
        mode_r.timebase_select == TB_EXT_FALL && tick
        |-> $past(external_count_input, 3) && !$past(external_count_input, 2))
        else $error("input fall tick not from synchronised pin");

    chk_div4_spacing: assert property (@(posedge aclk) disable iff (!aresetn) // [R4]
        tick && mode_r.timebase_select == TB_DIV4 && $stable(mode_r)
        |=> !tick [*3])
        else $error("clock/4 tick too close");

    chk_sysclk_step: assert property (@(posedge aclk) disable iff (!aresetn) // [R4] [R18]
        mode_r.timebase_select == TB_SYSCLK && run && !wr_low && !wr_high
        |=> count_r == $past(count_r) + 16'h0001)
        else $error("system clock timebase missed a count");

    chk_reserved_idle: assert property (@(posedge aclk) disable iff (!aresetn) // [R4]
        mode_r.timebase_select[2:1] == 2'b11 |-> !tick)
        else $error("reserved timebase produced a tick");

    chk_flag_on_wrap: assert property (@(posedge aclk) disable iff (!aresetn) // [R7]
        $rose(status_r.overflow) |-> $past(count_r) == `COUNT_ALL_ONES)
        else $error("overflow flag without wrap");

    chk_status_clear: assert property (@(posedge aclk) disable iff (!aresetn) // [R9]
        clr_vec.overflow && !set_vec.overflow |=> !status_r.overflow)
        else $error("overflow flag survived its clear");

    chk_ovf_request: assert property (@(posedge aclk) disable iff (!aresetn) // [R8] [R14]
        status_r.overflow && enable_r.overflow |-> irq_request)
        else $error("enabled overflow flag gave no request");

    chk_count_lock: assert property (@(posedge aclk) disable iff (!aresetn) // [R17]
        wr_take && mode_r.wdt_enable && !(run && tick) &&
        (s_axi_awaddr == `ADDR_COUNT_LOW || s_axi_awaddr == `ADDR_COUNT_HIGH)
        |=> $stable(count_r))
        else $error("count written while watchdog on");

    // Scenarios worth seeing
    cov_wrap: cover property (@(posedge aclk) disable iff (!aresetn) ovf_set);
    cov_idle_hold: cover property (@(posedge aclk) disable iff (!aresetn)
        mode_r.idle_suspend && cpu_idle);
    cov_snapshot_pair: cover property (@(posedge aclk) disable iff (!aresetn)
        rd_take && s_axi_araddr == `ADDR_COUNT_LOW ##[1:20]
        rd_take && s_axi_araddr == `ADDR_COUNT_HIGH);
    cov_set_clear: cover property (@(posedge aclk) disable iff (!aresetn)
        ovf_set && clr_vec.overflow);
    cov_cpu_irq: cover property (@(posedge aclk) disable iff (!aresetn) cpu_irq);

endmodule // pca_counter_array

/* logic/pca_regs.svh */
// Register map, field positions, reset values and timing counts of the counter array
// Notes on behaviour
// [R1] A 16-bit counter, seen by software as a low byte and a high byte.
// [R2] Reading the low byte snapshots the high byte; the next high read returns it.
// [R3] Reading either byte never pauses or alters counting.
// [R4] Timebase select: clk/12, clk/4, timer0 overflow, input falls, clk, osc/8.
// [R5] The outside source keeps input falling edges no faster than clock/4.
// [R6] The oscillator/8 tick is synchronised to the system clock before use.
// [R7] Wrap from all ones to zero sets the counter overflow flag.
// [R8] Counter overflow requests an interrupt only while its enable is one.
// [R9] The overflow flag is never cleared by vectoring; software clears it.
// [R10] With idle suspend at zero the array keeps counting while the CPU idles.
// [R11] Intermediate overflow flag sets on carry out of bit 8..11, per cycle length.
// [R12] Five channel event flags, one per capture/compare module.
// [R13] Every event flag sets on its trigger whatever its enable says.
// [R14] Array request is the OR of each flag gated by its own enable.
// [R15] The CPU sees the request only with global and array enables both one.
// [R16] Five 16-bit capture/compare modules, each with its own I/O line.
// [R17] Module 4 may act as watchdog; on after reset, restricting register access.
// [R18] The counter adds one per selected tick and wraps modulo 65536.
// [R19] With idle suspend at one the counter holds while the CPU idles.
`ifndef PCA_REGS_SVH
`define PCA_REGS_SVH

// Byte addresses of the registers
`define ADDR_MODE 12'h000
`define ADDR_COUNT_LOW 12'h004
`define ADDR_COUNT_HIGH 12'h008
`define ADDR_STATUS 12'h00C
`define ADDR_ENABLE 12'h010
`define ADDR_IRQ_CTRL 12'h014

// Mode and status register fields
`define MODE_WIDTH 7
`define MODE_RESET 7'h40
`define STATUS_WIDTH 7
`define STATUS_OVF_BIT 0
`define STATUS_INTER_BIT 1

// Interrupt control fields
`define IRQ_GLOBAL_BIT 0
`define IRQ_ARRAY_BIT 1

// Prescaler for the divided system clock ticks, and the counter's all-ones value
`define DIV12_LAST 4'hB
`define DIV4_PHASE 2'h3
`define COUNT_ALL_ONES 16'hFFFF

`endif

/* logic/pca_pkg.sv */
// Types shared by the counter array logic
package pca_pkg;

    typedef enum logic [2:0] {
        TB_DIV12 = 3'b000,
        TB_DIV4 = 3'b001,
        TB_TIMER0 = 3'b010,
        TB_EXT_FALL = 3'b011,
        TB_SYSCLK = 3'b100,
        TB_XOSC8 = 3'b101
    } timebase_t;

    typedef struct packed {
        logic wdt_enable;
        logic [1:0] cycle_len;
        logic idle_suspend;
        logic [2:0] timebase_select;
    } mode_t;

    typedef struct packed {
        logic [4:0] channel;
        logic intermediate;
        logic overflow;
    } event_t;

endpackage

/* testbench/tb.sv */
// Self-checking bench for the counter array, driven over its register bus
`timescale 1ns/100ps
`include "pca_regs.svh"

module tb;
    import pca_pkg::*;
    logic aclk, aresetn;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic external_count_input, xosc_div8_in, timer0_overflow, cpu_idle;
    logic [4:0] channel_event;
    logic [15:0] count_value;
    mode_t mode_o;
    logic irq_request, cpu_irq;
    int n_mismatch = 0;
    int checked = 0;
    int cycles = 0;

    pca_counter_array #(.CHANNELS(5)) i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .external_count_input,
        .xosc_div8_in, .timer0_overflow, .cpu_idle, .channel_event, .count_value, .mode_o,
        .irq_request, .cpu_irq);

    // 40 MHz system clock
    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end

    // Cuts a hung run short
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            n_mismatch = n_mismatch + 1;
            complete_run();
        end
    end

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Counts taken from free-running ticks tolerate a few cycles of bus latency
    task automatic chk_near(input string what, input int exp, input logic [15:0] got);
        checked++;
        if ($isunknown(got) || int'(got) < exp - 4 || int'(got) > exp + 4) begin
            n_mismatch++;
            $display("wrong value %s expected %0d seen %h", what, exp, got);
        end
    endtask

    // Write with address and data offered together, held until taken
    task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do @(posedge aclk); while (!(s_axi_awready && s_axi_wready));
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        s_axi_bready <= 1'b1;
        do @(posedge aclk); while (!s_axi_bvalid);
        chk("write response", {30'h0, er}, {30'h0, s_axi_bresp});
        s_axi_bready <= 1'b0;
    endtask

    task automatic axi_read(input logic [11:0] a, output logic [31:0] d, input logic [1:0] er);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (!s_axi_rvalid);
        d = s_axi_rdata;
        chk("read response", {30'h0, er}, {30'h0, s_axi_rresp});
        s_axi_rready <= 1'b0;
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] d;
        axi_read(a, d, 2'b00);
        chk("register read", exp, d);
    endtask

    // Low byte first so that the high byte comes from the snapshot
    task automatic get_count(output logic [15:0] v);
        logic [31:0] lo, hi;
        axi_read(`ADDR_COUNT_LOW, lo, 2'b00);
        axi_read(`ADDR_COUNT_HIGH, hi, 2'b00);
        v = {hi[7:0], lo[7:0]};
    endtask

    task automatic set_count(input logic [15:0] v);
        axi_write(`ADDR_COUNT_LOW, {24'h00_0000, v[7:0]}, 2'b00);
        axi_write(`ADDR_COUNT_HIGH, {24'h00_0000, v[15:8]}, 2'b00);
    endtask

    // One timer 0 overflow pulse, then time for the flags to land
    task automatic tick0();
        @(posedge aclk);
        timer0_overflow <= 1'b1;
        @(posedge aclk);
        timer0_overflow <= 1'b0;
        repeat (3) @(posedge aclk);
    endtask

    task automatic test_reset();
        logic [15:0] v;
        chk("mode after reset", 32'h0000_0040, {25'h0, mode_o});
        rd_chk(`ADDR_MODE, 32'h0000_0040);
        axi_write(`ADDR_COUNT_HIGH, 32'h0000_00AB, 2'b00);
        axi_write(`ADDR_MODE, 32'h0000_0045, 2'b00);
        rd_chk(`ADDR_MODE, 32'h0000_0040);
        axi_write(`ADDR_MODE, 32'h0000_0005, 2'b00);
        rd_chk(`ADDR_MODE, 32'h0000_0000);
        get_count(v);
        chk("locked count write", 32'h0000_0000, {24'h0, v[15:8]});
    endtask

    task automatic test_snapshot();
        logic [15:0] v;
        axi_write(`ADDR_MODE, 32'h0000_0002, 2'b00);
        set_count(16'h12FF);
        rd_chk(`ADDR_COUNT_LOW, 32'h0000_00FF);
        tick0();
        rd_chk(`ADDR_COUNT_HIGH, 32'h0000_0012);
        get_count(v);
        chk("count after tick", 32'h0000_1300, {16'h0, v});
        chk("count port", 32'h0000_1300, {16'h0, count_value});
    endtask

    task automatic test_rates();
        logic [2:0] code[3] = '{3'b000, 3'b001, 3'b100};
        int div[3] = '{12, 4, 1};
        logic [15:0] v;
        for (int i = 0; i < 3; i++) begin
            axi_write(`ADDR_MODE, 32'h0000_0006, 2'b00);
            set_count(16'h0000);
            axi_write(`ADDR_MODE, {29'h0, code[i]}, 2'b00);
            repeat (100 * div[i]) @(posedge aclk);
            axi_write(`ADDR_MODE, 32'h0000_0006, 2'b00);
            get_count(v);
            chk_near("timebase count", 100, v);
        end
    endtask

    // Both pins toggle; the selected timebase decides which edges count
    task automatic test_pins();
        logic [15:0] v;
        for (int j = 3; j < 6; j += 2) begin
            axi_write(`ADDR_MODE, 32'h0000_0006, 2'b00);
            set_count(16'h0000);
            axi_write(`ADDR_MODE, j, 2'b00);
            repeat (10) begin
                external_count_input <= 1'b1;
                xosc_div8_in <= 1'b1;
                repeat (4) @(posedge aclk);
                external_count_input <= 1'b0;
                xosc_div8_in <= 1'b0;
                repeat (4) @(posedge aclk);
            end
            repeat (8) @(posedge aclk);
            get_count(v);
            chk("pin edge count", 32'h0000_000A, {16'h0, v});
        end
    endtask

    task automatic test_idle();
        logic [15:0] a, b;
        axi_write(`ADDR_MODE, 32'h0000_0004, 2'b00);
        cpu_idle <= 1'b1;
        get_count(a);
        repeat (20) @(posedge aclk);
        get_count(b);
        chk("counting in idle", 32'h0000_0001, {31'h0, b != a});
        axi_write(`ADDR_MODE, 32'h0000_000C, 2'b00);
        repeat (2) @(posedge aclk);
        get_count(a);
        repeat (50) @(posedge aclk);
        get_count(b);
        chk("held in idle", {16'h0, a}, {16'h0, b});
        cpu_idle <= 1'b0;
    endtask

    task automatic test_irq();
        logic [15:0] v;
        axi_write(`ADDR_MODE, 32'h0000_0002, 2'b00);
        set_count(16'hFFFF);
        tick0();
        get_count(v);
        chk("wrapped count", 32'h0000_0000, {16'h0, v});
        rd_chk(`ADDR_STATUS, 32'h0000_0003);
        chk("masked request", 32'h0, {31'h0, irq_request});
        axi_write(`ADDR_ENABLE, 32'h0000_0001, 2'b00);
        chk("overflow request", 32'h1, {31'h0, irq_request});
        for (int g = 0; g < 4; g++) begin
            axi_write(`ADDR_IRQ_CTRL, g, 2'b00);
            chk("cpu request", {31'h0, g == 3}, {31'h0, cpu_irq});
        end
        repeat (20) @(posedge aclk);
        rd_chk(`ADDR_STATUS, 32'h0000_0003);
        axi_write(`ADDR_STATUS, 32'h0000_0003, 2'b00);
        chk("cleared request", 32'h0, {31'h0, irq_request});
        rd_chk(`ADDR_STATUS, 32'h0000_0000);
    endtask

    task automatic test_events();
        for (int i = 0; i < 5; i++) begin
            channel_event <= 5'h01 << i;
            @(posedge aclk);
            channel_event <= 5'h00;
            repeat (2) @(posedge aclk);
            rd_chk(`ADDR_STATUS, 32'h0000_0004 << i);
            chk("other channel gated", 32'h0, {31'h0, irq_request});
            axi_write(`ADDR_ENABLE, 32'h0000_0004 << i, 2'b00);
            chk("channel request", 32'h1, {31'h0, irq_request});
            axi_write(`ADDR_STATUS, 32'h0000_0004 << i, 2'b00);
        end
        for (int k = 0; k < 4; k++) begin
            axi_write(`ADDR_MODE, 32'h0000_0002 | (k << 4), 2'b00);
            set_count(16'((32'h1 << (8 + k)) - 1));
            tick0();
            rd_chk(`ADDR_STATUS, 32'h0000_0002);
            axi_write(`ADDR_ENABLE, 32'h0000_0002, 2'b00);
            chk("intermediate request", 32'h1, {31'h0, irq_request});
            axi_write(`ADDR_STATUS, 32'h0000_0002, 2'b00);
        end
    endtask

    task automatic test_unmapped();
        logic [31:0] d;
        axi_write(12'h020, 32'h0000_0001, 2'b10);
        axi_read(12'h020, d, 2'b10);
        chk("unmapped read data", 32'h0000_0000, d);
    endtask

    // Main sequence
    initial begin
        aresetn = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        s_axi_awaddr = 12'h000;
        s_axi_araddr = 12'h000;
        s_axi_wdata = 32'h0000_0000;
        s_axi_wstrb = 4'hF;
        {external_count_input, xosc_div8_in, timer0_overflow, cpu_idle} = 4'h8;
        channel_event = 5'h00;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        test_reset();
        test_snapshot();
        test_rates();
        test_pins();
        test_idle();
        test_irq();
        test_events();
        test_unmapped();
        complete_run();
    end
endmodule // tb
